// file: hdl/wseq_pkg.sv
// constants and types shared by the waveform sequencer slot block
package wseq_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] CTRL_IDX       = 6'h0c;
  localparam logic [5:0] SLOT_FIRST_IDX = 6'h0f;
  localparam logic [5:0] SLOT7_IDX      = 6'h15;
  localparam logic [5:0] SLOT8_IDX      = 6'h16;
  localparam logic [5:0] LOOP_LO_IDX    = 6'h17;
  localparam logic [5:0] LOOP_HI_IDX    = 6'h18;
  localparam logic [5:0] STATUS_IDX     = 6'h20;

  // field positions
  localparam int GO_BIT        = 0;
  localparam int SLOT_FLAG_BIT = 7;
  localparam int REPEAT_W      = 2;

  // reset values
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [7:0] LOOP_RESET = 8'h00;
  localparam logic       GO_RESET   = 1'b0;

  // sequencer geometry
  localparam int         SLOT_COUNT = 8;
  localparam logic [2:0] LAST_SLOT  = 3'h7;

  // wait unit timing
  localparam int WAIT_UNIT_MS     = 10;
  localparam int CLK_HZ           = 25_000_000;
  localparam int WAIT_UNIT_CYCLES = CLK_HZ / 1000 * WAIT_UNIT_MS;

  typedef struct packed {
    logic       delay_flag;
    logic [6:0] effect_value;
  } slot_t;

  typedef struct packed {
    logic       start;
    logic [6:0] id;
  } effect_req_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_PLAY,
    ST_WAIT,
    ST_NEXT
  } seq_state_t;

  typedef struct packed {
    slot_t [SLOT_COUNT-1:0]   slot;
    logic [2*SLOT_COUNT-1:0]  loops;
    logic                     go;
    seq_state_t               st;
    logic [2:0]               idx;
    logic [REPEAT_W-1:0]      rep;
    logic [6:0]               wait_left;
    effect_req_t              effect;
    logic [31:0]              prdata;
  } seq_regs_t;

endpackage

// file: hdl/wait_prescaler.sv
// wait unit prescaler: one tick per wait unit, restartable
`timescale 1ns/1ns
module wait_prescaler
  import wseq_pkg::*;
#(
  parameter int UNIT_CYCLES = WAIT_UNIT_CYCLES
)(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // control
  input  wire logic restart_in,
  // tick
  output logic      tick_out
);

  localparam int CNT_W = $clog2(UNIT_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(UNIT_CYCLES - 1);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             tick;
  } presc_state_t;

  presc_state_t r_q;
  presc_state_t r_d;

  always_comb
  begin
    r_d      = r_q;
    r_d.tick = 1'b0;
    if (restart_in)
    begin
      r_d.count = '0;                                   // R08
    end
    else if (r_q.count == LAST)
    begin
      r_d.count = '0;
      r_d.tick  = 1'b1;                                 // R08
    end
    else
    begin
      r_d.count = r_q.count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign tick_out = r_q.tick;

endmodule // wait_prescaler

// file: hdl/wseq_slots.sv
// waveform sequencer with slot registers and APB register access
//
// Function
// R01: a slot whose delay flag is 1 idles the engine for its value times 10 ms.
// R02: a slot whose delay flag is 0 plays its 7-bit value as a library effect index.
// R03: setting the go bit in the control register starts playback at the first slot.
// R04: after a slot finishes the sequencer moves to the next slot and plays it if nonzero.
// R05: playback ends after the eighth slot or at a zero identifier, whichever is first.
// R06: a zero identifier stops playback and nothing is played for that slot.
// R07: each slot is played its 2-bit repeat count plus one times before moving on.
// R08: the 10 ms unit comes from a prescaler restarted at the start of every wait.
`timescale 1ns/1ns
module wseq_slots
  import wseq_pkg::*;
#(
  parameter int UNIT_CYCLES = WAIT_UNIT_CYCLES
)(
  // clock and reset
  input  wire logic         CLK_IN,
  input  wire logic         RESETN_IN,
  // apb slave
  input  wire logic         PSEL_IN,
  input  wire logic         PENABLE_IN,
  input  wire logic         PWRITE_IN,
  input  wire logic [7:0]   PADDR_IN,
  input  wire logic [31:0]  PWDATA_IN,
  output logic [31:0]       PRDATA_OUT,
  output logic              PREADY_OUT,
  output logic              PSLVERR_OUT,
  // effect library side
  output effect_req_t       EFFECT_REQ_OUT,
  input  wire logic         EFFECT_DONE_IN,
  // sequencer status
  output logic              SEQ_BUSY_OUT,
  output logic              SEQ_DELAY_OUT
);

  logic       rst_meta_q;
  logic       rst_n_q;
  seq_regs_t  r_q;
  seq_regs_t  r_d;
  logic       tick;
  logic       restart;
  logic [5:0] reg_idx;
  logic       aligned;
  logic       is_slot;
  logic [2:0] slot_sel;
  logic       mapped;
  logic       access;
  logic       wr_en;
  logic [7:0] wbyte;
  logic [31:0] rd_val;
  slot_t      cur;
  logic [REPEAT_W-1:0] rep_limit;

  // reset release through two flops
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  wait_prescaler #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_prescaler (
    .clk_in     (CLK_IN),
    .rst_n_in   (rst_n_q),
    .restart_in (restart),
    .tick_out   (tick)
  );

  // address decode
  assign reg_idx  = PADDR_IN[7:2];
  assign aligned  = (PADDR_IN[1:0] == 2'b00);
  assign is_slot  = (reg_idx >= SLOT_FIRST_IDX) && (reg_idx <= SLOT8_IDX);
  assign slot_sel = 3'(reg_idx - SLOT_FIRST_IDX);
  assign mapped   = aligned && (is_slot || reg_idx == CTRL_IDX || reg_idx == LOOP_LO_IDX ||
                                reg_idx == LOOP_HI_IDX || reg_idx == STATUS_IDX);
  assign access   = PSEL_IN && PENABLE_IN;
  assign wr_en    = access && PWRITE_IN && mapped;
  assign wbyte    = PWDATA_IN[7:0];

  // read data mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (!aligned)
    begin
      rd_val = 32'h0000_0000;
    end
    else if (is_slot)
    begin
      rd_val[7:0] = r_q.slot[slot_sel];
    end
    else if (reg_idx == CTRL_IDX)
    begin
      rd_val[GO_BIT] = r_q.go;
    end
    else if (reg_idx == LOOP_LO_IDX)
    begin
      rd_val[7:0] = r_q.loops[7:0];
    end
    else if (reg_idx == LOOP_HI_IDX)
    begin
      rd_val[7:0] = r_q.loops[15:8];
    end
    else if (reg_idx == STATUS_IDX)
    begin
      rd_val[0]   = (r_q.st != ST_IDLE);
      rd_val[1]   = (r_q.st == ST_WAIT);
      rd_val[2]   = (r_q.st == ST_PLAY);
      rd_val[5:3] = r_q.idx;
      rd_val[7:6] = r_q.rep;
    end
  end

  assign cur       = r_q.slot[r_q.idx];
  assign rep_limit = r_q.loops[{r_q.idx, 1'b0} +: REPEAT_W];

  // sequencer and register file
  always_comb
  begin
    r_d              = r_q;
    r_d.effect.start = 1'b0;
    restart          = 1'b0;

    unique case (r_q.st)
      ST_IDLE:
      begin
        if (r_q.go)
        begin
          r_d.st  = ST_FETCH;
          r_d.idx = 3'h0;                                 // R03
          r_d.rep = '0;
        end
      end
      ST_FETCH:
      begin
        if (!cur.delay_flag && cur.effect_value == 7'h00)
        begin
          r_d.st = ST_IDLE;                               // R06
          r_d.go = 1'b0;                                  // R05
        end
        else if (cur.delay_flag)
        begin
          r_d.wait_left = cur.effect_value;               // R01
          restart       = 1'b1;                           // R08
          r_d.st        = ST_WAIT;
        end
        else
        begin
          r_d.effect.start = 1'b1;                        // R02
          r_d.effect.id    = cur.effect_value;            // R02
          r_d.st           = ST_PLAY;
        end
      end
      ST_PLAY:
      begin
        if (EFFECT_DONE_IN)
        begin
          r_d.st = ST_NEXT;
        end
      end
      ST_WAIT:
      begin
        if (r_q.wait_left == 7'h00)
        begin
          r_d.st = ST_NEXT;
        end
        else if (tick)
        begin
          r_d.wait_left = r_q.wait_left - 7'h01;          // R01
        end
      end
      ST_NEXT:
      begin
        if (r_q.rep != rep_limit)
        begin
          r_d.rep = r_q.rep + 2'(1);                      // R07
          r_d.st  = ST_FETCH;
        end
        else if (r_q.idx == LAST_SLOT)
        begin
          r_d.st = ST_IDLE;                               // R05
          r_d.go = 1'b0;
        end
        else
        begin
          r_d.idx = r_q.idx + 3'h1;                       // R04
          r_d.rep = '0;
          r_d.st  = ST_FETCH;
        end
      end
      default:
      begin
        r_d.st = ST_IDLE;
      end
    endcase

    // read data captured in the setup phase
    if (PSEL_IN && !PENABLE_IN)
    begin
      r_d.prdata = rd_val;
    end

    // software writes come last so a set of go wins over its clear
    if (wr_en)
    begin
      if (is_slot)
      begin
        r_d.slot[slot_sel] = wbyte;
      end
      else if (reg_idx == CTRL_IDX)
      begin
        r_d.go = wbyte[GO_BIT];                           // R03
        if (!wbyte[GO_BIT])
        begin
          // abort also drops a start launched this cycle
          r_d.st           = ST_IDLE;
          r_d.effect.start = 1'b0;
        end
      end
      else if (reg_idx == LOOP_LO_IDX)
      begin
        r_d.loops[7:0] = wbyte;                           // R07
      end
      else if (reg_idx == LOOP_HI_IDX)
      begin
        r_d.loops[15:8] = wbyte;                          // R07
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      r_q       <= '0;
      r_q.slot  <= {SLOT_COUNT{SLOT_RESET}};
      r_q.loops <= {LOOP_RESET, LOOP_RESET};
      r_q.go    <= GO_RESET;
      r_q.st    <= ST_IDLE;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // outputs
  assign PRDATA_OUT     = r_q.prdata;
  assign PREADY_OUT     = 1'b1;
  assign PSLVERR_OUT    = access && !mapped;
  assign EFFECT_REQ_OUT = r_q.effect;
  assign SEQ_BUSY_OUT   = (r_q.st != ST_IDLE);
  assign SEQ_DELAY_OUT  = (r_q.st == ST_WAIT);

endmodule // wseq_slots

// file: sim/wseq_slots_asserts.sv
// assertion checker for the waveform sequencer slot block
`timescale 1ns/1ns
module wseq_slots_asserts
  import wseq_pkg::*;
(
  input wire logic        CLK_IN,
  input wire logic        RESETN_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire effect_req_t EFFECT_REQ_OUT,
  input wire logic        EFFECT_DONE_IN,
  input wire logic        SEQ_BUSY_OUT,
  input wire logic        SEQ_DELAY_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  sequence s_go;
    PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == {CTRL_IDX, 2'b00} && PWDATA_IN[GO_BIT];
  endsequence
  sequence s_done;
    EFFECT_DONE_IN && SEQ_BUSY_OUT && !SEQ_DELAY_OUT && !EFFECT_REQ_OUT.start;
  endsequence
  AST_GO_BUSY: assert property (s_go ##0 !SEQ_BUSY_OUT |-> ##[1:3] SEQ_BUSY_OUT)
    else $error("go ignored");
  AST_DONE_NEXT: assert property (s_done |-> ##[1:5] (EFFECT_REQ_OUT.start
    || SEQ_DELAY_OUT || !SEQ_BUSY_OUT))
    else $error("no step after done");
  AST_DELAY_QUIET: assert property (SEQ_DELAY_OUT |-> !EFFECT_REQ_OUT.start)
    else $error("effect during delay");
  AST_DELAY_BUSY: assert property (SEQ_DELAY_OUT |-> SEQ_BUSY_OUT)
    else $error("delay while idle");
  AST_START_BUSY: assert property (EFFECT_REQ_OUT.start |-> SEQ_BUSY_OUT)
    else $error("start while idle");
  AST_START_PULSE: assert property (EFFECT_REQ_OUT.start |=> !EFFECT_REQ_OUT.start)
    else $error("start too long");
  AST_ID_HOLD: assert property (!EFFECT_REQ_OUT.start |-> $stable(EFFECT_REQ_OUT.id))
    else $error("id moved");
  AST_NO_ZERO: assert property (EFFECT_REQ_OUT.start |-> EFFECT_REQ_OUT.id != 7'h00)
    else $error("zero id played");
endmodule // wseq_slots_asserts

bind wseq_slots wseq_slots_asserts u_asserts (
  .CLK_IN(CLK_IN),
  .RESETN_IN(RESETN_IN),
  .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN),
  .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN),
  .EFFECT_REQ_OUT(EFFECT_REQ_OUT),
  .EFFECT_DONE_IN(EFFECT_DONE_IN),
  .SEQ_BUSY_OUT(SEQ_BUSY_OUT),
  .SEQ_DELAY_OUT(SEQ_DELAY_OUT)
);

// file: sim/wseq_slots_test.sv
// self-checking bench for the waveform sequencer slot block
`timescale 1ns/1ns
module wseq_slots_test
  import wseq_pkg::*;
;
  localparam int UC = 8;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        done = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, busy, dly;
  effect_req_t req;
  logic [6:0]  ids[$];
  int          dcnt = 0;
  int          dly_cycles = 0;
  int          fail_count = 0;
  int          samples_checked = 0;
  logic [7:0]  r;
  logic        e;

  always #20 clk = ~clk;

  wseq_slots #(.UNIT_CYCLES(UC)) u_dut (
    .CLK_IN(clk),
    .RESETN_IN(rstn),
    .PSEL_IN(psel),
    .PENABLE_IN(penable),
    .PWRITE_IN(pwrite),
    .PADDR_IN(paddr),
    .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata),
    .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr),
    .EFFECT_REQ_OUT(req),
    .EFFECT_DONE_IN(done),
    .SEQ_BUSY_OUT(busy),
    .SEQ_DELAY_OUT(dly)
  );

  // library stand-in: done pulse four cycles after each start
  always @(posedge clk)
  begin
    done <= (dcnt == 1);
    if (req.start === 1'b1)
    begin
      ids.push_back(req.id);
      dcnt <= 3;
    end
    else if (dcnt > 0)
      dcnt <= dcnt - 1;
    if (dly === 1'b1) dly_cycles <= dly_cycles + 1;
  end

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    samples_checked++;
    if (g !== x)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run;
    ids.delete();
    dly_cycles = 0;
    apb(1'b1, CTRL_IDX, 8'h01);
    repeat (3) @(posedge clk);
    for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge clk);
    chk("idle", 8'h00, {7'h0, busy});
    apb(1'b0, CTRL_IDX, 8'h00);
  endtask

  task automatic t_abort;
    apb(1'b1, CTRL_IDX, 8'h01);
    apb(1'b0, STATUS_IDX, 8'h00);
    chk("status fetch", 8'h01, r);
    apb(1'b1, CTRL_IDX, 8'h00);
    @(posedge clk);
    chk("abort busy", 8'h00, {7'h0, busy});
    apb(1'b0, CTRL_IDX, 8'h00);
    chk("abort go", 8'h00, r);
  endtask

  task automatic t_regs;
    apb(1'b0, SLOT7_IDX, 8'h00);
    chk("slot7 reset", SLOT_RESET, r);
    apb(1'b0, SLOT8_IDX, 8'h00);
    chk("slot8 reset", SLOT_RESET, r);
    apb(1'b0, 6'h30, 8'h00);
    chk("unmapped err", 8'h01, {7'h0, e});
    chk("unmapped data", 8'h00, r);
  endtask

  task automatic t_seq;
    for (int k = 0; k < 6; k++) apb(1'b1, SLOT_FIRST_IDX + 6'(k), 8'h11 + 8'(k));
    apb(1'b1, SLOT7_IDX, 8'h82);
    apb(1'b1, SLOT8_IDX, 8'h7f);
    apb(1'b1, LOOP_HI_IDX, 8'hc0);
    apb(1'b0, SLOT7_IDX, 8'h00);
    chk("slot7 rw", 8'h82, r);
    run();
    chk("go", 8'h00, r);
    chk("plays", 8'd10, 8'(ids.size()));
    for (int k = 0; k < 10; k++) chk("id", (k < 6) ? 8'h11 + 8'(k) : 8'h7f, {1'b0, ids[k]});
    chk("delay min", 8'h01, {7'h0, dly_cycles >= 2 * UC});
    chk("delay max", 8'h01, {7'h0, dly_cycles <= 2 * UC + 4});
  endtask

  task automatic t_zero;
    apb(1'b1, SLOT_FIRST_IDX + 6'h2, 8'h00);
    run();
    chk("plays", 8'd2, 8'(ids.size()));
    chk("id", 8'h12, {1'b0, ids[1]});
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_seq();
    t_zero();
    t_abort();
    end_sim();
  end
endmodule // wseq_slots_test
